/* hw/rcbc_top.sv */
`timescale 1ns/1ps
// Operation
// - Low five cause bits are flags cleared by their events; software sets bits 4, 1 and 0 only.
// - Bit 7 is read/write interrupt priority enable, reset 0.
// - Bit 6 software brown-out enable acts only in mode 01, else reads 0.
// - Bit 6 resets to 1 in software brown-out mode, otherwise 0.
// - Bit 5 ignores writes and reads 0.
// - Bit 4 cleared by reset instruction, set by firmware or by power-on or brown-out reset.
// - Bit 3 set by power-up, watchdog clear, sleep; cleared by watchdog time-out.
// - Bit 2 set by power-up or watchdog clear; cleared by sleep.
// - Bit 1 cleared on power-on reset only; set only by software.
// - Bit 0 cleared on brown-out or power-on reset while detection enabled.
// - Held in reset while pin low; short low pulses filtered out.
// - The reset pin is never driven low by internal resets.
// - With pin function disabled the pin is a plain digital input.
// - Brown-out mode: 00 off, 01 software, 10 off in sleep, 11 on.
// - Low supply longer than minimum duration resets until supply recovers.
// - Power-up delay starts after recovery; new drop restarts it.
// - Brown-out and power-up delay are enabled independently.
// - Mode 10 disables detection in sleep, re-enables outside it.
// - Trip level comes only from level configuration bits.
// - Power-up delay counts 2048 slow oscillator periods, holding reset.
// - Power-up delay enabled when its off bit is 0.
// - Oscillator start-up timer adds 1024 crystal cycles after the delay.
// - With PLL enabled a 2 ms lock wait follows the oscillator timer.
module rcbc_top #(
  parameter int POWERUP_DELAY_TIMER_CNT = rcbc_pkg::POWERUP_DELAY_TIMER_TICKS,
  parameter int OST_CNT  = rcbc_pkg::OST_TICKS,
  parameter int PLL_CNT  = rcbc_pkg::PLL_LOCK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_reset_pin_in,
  output logic             ext_reset_pin_out,
  output logic             ext_reset_pin_oe,
  output logic             ext_pin_din,
  input  wire logic        por_pulse,
  input  wire logic        supply_low,
  input  wire logic        internal_slow_osc,
  input  wire logic        xtal_osc_in,
  input  wire logic        ext_reset_pin_enable,
  input  wire logic        powerup_delay_off,
  input  wire logic        osc_startup_en,
  input  wire logic        pll_enable,
  input  wire logic [1:0]  brownout_cfg,
  input  wire logic [1:0]  brownout_level_cfg,
  input  wire logic        sleep_mode,
  input  wire logic        reset_instr_evt,
  input  wire logic        watchdog_timeout_evt,
  input  wire logic        watchdog_clear_evt,
  input  wire logic        sleep_evt,
  output logic             device_reset_n,
  output logic             irq_priority_enable,
  output logic             brownout_det_en,
  output logic [1:0]       brownout_level
);
  import rcbc_pkg::*;

  logic [1:0]     pin_s_q;
  logic [1:0]     por_s_q;
  logic [1:0]     low_s_q;
  logic [1:0]     slow_s_q;
  logic [1:0]     xtal_s_q;
  logic           slow_d_q;
  logic           xtal_d_q;
  logic [15:0]    pin_cnt_q;
  logic           pin_rst_q;
  logic [15:0]    low_cnt_q;
  logic           bor_act_q;
  logic           bor_act_d_q;
  logic           bor_en;
  logic           bor_trip;
  logic           slow_tick;
  logic           xtal_tick;
  rcbc_state_type st_q;
  rcbc_state_type st_d;
  logic [31:0]    tmr_q;
  logic           tmr_done;
  logic           int_rst_q;
  logic           irq_priority_enable_q;
  logic           sbor_q;
  logic           ri_q;
  logic           to_q;
  logic           pd_q;
  logic           porf_q;
  logic           borf_q;
  logic           acc;
  logic           wr_rcc;
  logic           map_hit;
  logic [7:0]     rcc_rd;
  logic           bor_rst_evt;

  // Two-flop synchronisers for pins and analog indications
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pin_s_q  <= 2'h3;
      por_s_q  <= 2'h0;
      low_s_q  <= 2'h0;
      slow_s_q <= 2'h0;
      xtal_s_q <= 2'h0;
    end
    else if (clk_en)
    begin
      pin_s_q  <= {pin_s_q[0], ext_reset_pin_in};
      por_s_q  <= {por_s_q[0], por_pulse};
      low_s_q  <= {low_s_q[0], supply_low};
      slow_s_q <= {slow_s_q[0], internal_slow_osc};
      xtal_s_q <= {xtal_s_q[0], xtal_osc_in};
    end

  // Edge history of the oscillator inputs
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      slow_d_q <= 1'b0;
      xtal_d_q <= 1'b0;
    end
    else if (clk_en)
    begin
      slow_d_q <= slow_s_q[1];
      xtal_d_q <= xtal_s_q[1];
    end

  assign slow_tick = slow_s_q[1] & ~slow_d_q;
  assign xtal_tick = xtal_s_q[1] & ~xtal_d_q;

  // Pin low must persist before it counts as a reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pin_cnt_q <= 16'h0000;
      pin_rst_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!ext_reset_pin_enable || pin_s_q[1])
      begin
        pin_cnt_q <= 16'h0000;
        pin_rst_q <= 1'b0;
      end
      else if (pin_cnt_q >= 16'(PIN_FILT_CYC - 1))
        pin_rst_q <= 1'b1;
      else
        pin_cnt_q <= pin_cnt_q + 16'h0001;
    end

  // Brown-out enable decode from mode, software bit and sleep
  always_comb
  begin
    case (brownout_cfg)
      BOR_SW:   bor_en = sbor_q;
      BOR_NOSL: bor_en = ~sleep_mode;
      BOR_ON:   bor_en = 1'b1;
      default:  bor_en = 1'b0;
    endcase
  end

  assign bor_trip = low_cnt_q >= 16'(BOR_MIN_CYC);

  // Low supply qualified by minimum duration, held until recovery
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      low_cnt_q <= 16'h0000;
      bor_act_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!bor_en || !low_s_q[1])
      begin
        low_cnt_q <= 16'h0000;
        bor_act_q <= 1'b0;
      end
      else if (bor_trip)
        bor_act_q <= 1'b1;
      else
        low_cnt_q <= low_cnt_q + 16'h0001;
    end

  // Previous brown-out state for event detection
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      bor_act_d_q <= 1'b0;
    else if (clk_en)
      bor_act_d_q <= bor_act_q;

  assign bor_rst_evt = bor_act_q & ~bor_act_d_q;
  assign tmr_done = (st_q == ST_POWERUP_DELAY_TIMER) ? (tmr_q >= 32'(POWERUP_DELAY_TIMER_CNT - 1)) & slow_tick
                  : (st_q == ST_OST) ? (tmr_q >= 32'(OST_CNT - 1)) & xtal_tick
                  : (tmr_q >= 32'(PLL_CNT - 1));

  // Start-up sequence: hold, power-up delay, oscillator, PLL
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_HOLD:
        if (!por_s_q[1] && !bor_act_q)
          st_d = !powerup_delay_off ? ST_POWERUP_DELAY_TIMER
               : osc_startup_en ? ST_OST
               : pll_enable ? ST_PLL : ST_DONE;
      ST_POWERUP_DELAY_TIMER:
        if (tmr_done)
          st_d = osc_startup_en ? ST_OST
               : pll_enable ? ST_PLL : ST_DONE;
      ST_OST:
        if (tmr_done)
          st_d = pll_enable ? ST_PLL : ST_DONE;
      ST_PLL:
        if (tmr_done)
          st_d = ST_DONE;
      ST_DONE:
        st_d = ST_DONE;
      default:
        st_d = ST_HOLD;
    endcase
    if (por_s_q[1] || bor_act_q)
      st_d = ST_HOLD;
  end

  // Sequencer state register
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      st_q <= ST_HOLD;
    else if (clk_en)
      st_q <= st_d;

  // Delay counter, restarted on every state change
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tmr_q <= 32'h0000_0000;
    else if (clk_en)
    begin
      if (st_d != st_q || st_q == ST_HOLD)
        tmr_q <= 32'h0000_0000;
      else if (st_q == ST_POWERUP_DELAY_TIMER && slow_tick)
        tmr_q <= tmr_q + 32'h0000_0001;
      else if (st_q == ST_OST && xtal_tick)
        tmr_q <= tmr_q + 32'h0000_0001;
      else if (st_q == ST_PLL)
        tmr_q <= tmr_q + 32'h0000_0001;
    end

  // One-cycle internal reset from instruction or watchdog in run
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      int_rst_q <= 1'b0;
    else if (clk_en)
      int_rst_q <= reset_instr_evt | (watchdog_timeout_evt & ~sleep_mode);

  // Combined device reset, released only when all sources are gone
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      device_reset_n <= 1'b0;
    else if (clk_en)
      device_reset_n <= (st_d == ST_DONE) & ~pin_rst_q & ~int_rst_q;

  // Pin is input only; digital value offered when reset use is off
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ext_reset_pin_out <= 1'b0;
      ext_reset_pin_oe  <= 1'b0;
      ext_pin_din       <= 1'b1;
    end
    else if (clk_en)
    begin
      ext_reset_pin_out <= 1'b0;
      ext_reset_pin_oe  <= 1'b0;
      ext_pin_din       <= pin_s_q[1] | ext_reset_pin_enable;
    end

  // Comparator enable and trip level to the analog monitor
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      brownout_det_en <= 1'b0;
      brownout_level  <= 2'h0;
    end
    else if (clk_en)
    begin
      brownout_det_en <= bor_en;
      brownout_level  <= brownout_level_cfg;
    end

  assign acc     = psel & penable & pready;
  assign map_hit = (paddr == RCC_OFFSET) || (paddr == STAT_OFFSET);
  assign wr_rcc  = acc & pwrite & (paddr == RCC_OFFSET);

  // Control bits: software stores, power-on restores defaults
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      irq_priority_enable_q <= IRQ_PRIORITY_ENABLE_RST;
      sbor_q <= SBOR_RST;
    end
    else if (clk_en)
    begin
      if (por_s_q[1])
      begin
        irq_priority_enable_q <= IRQ_PRIORITY_ENABLE_RST;
        sbor_q <= SBOR_RST;
      end
      else if (wr_rcc)
      begin
        irq_priority_enable_q <= pwdata[IRQ_PRIORITY_ENABLE_BIT];
        sbor_q <= pwdata[SBOR_BIT];
      end
    end

  // Cause flags; hardware events override a write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ri_q   <= RI_RST;
      to_q   <= TO_RST;
      pd_q   <= PD_RST;
      porf_q <= POR_RST;
      borf_q <= BOR_RST;
    end
    else if (clk_en)
    begin
      if (wr_rcc)
      begin
        ri_q   <= pwdata[RI_BIT];
        porf_q <= pwdata[POR_BIT];
        borf_q <= pwdata[BOR_BIT];
      end
      if (por_s_q[1] || bor_rst_evt)
      begin
        ri_q <= 1'b1;
        to_q <= 1'b1;
        pd_q <= 1'b1;
      end
      if (por_s_q[1])
        porf_q <= 1'b0;
      if ((por_s_q[1] && bor_en) || bor_rst_evt)
        borf_q <= 1'b0;
      if (reset_instr_evt)
        ri_q <= 1'b0;
      if (watchdog_clear_evt)
      begin
        to_q <= 1'b1;
        pd_q <= 1'b1;
      end
      if (sleep_evt)
      begin
        to_q <= 1'b1;
        pd_q <= 1'b0;
      end
      if (watchdog_timeout_evt)
      begin
        to_q <= 1'b0;
        if (sleep_mode)
          pd_q <= 1'b0;
      end
    end

  assign rcc_rd = {irq_priority_enable_q, sbor_q & (brownout_cfg == BOR_SW), 1'b0,
                   ri_q, to_q, pd_q, porf_q, borf_q};

  // Interrupt priority enable output
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_priority_enable <= IRQ_PRIORITY_ENABLE_RST;
    else if (clk_en)
      irq_priority_enable <= irq_priority_enable_q;

  // APB slave: one wait state, registered answer
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~map_hit;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite)
      begin
        if (paddr == RCC_OFFSET)
          prdata <= {24'h000000, rcc_rd};
        else if (paddr == STAT_OFFSET)
          prdata <= {22'h000000, bor_act_q, pin_rst_q, ~device_reset_n, 2'h0, st_q}; // Status word layout
      end
    end

endmodule // rcbc_top

/* hw/rcbc_pkg.sv */
package rcbc_pkg;
  // Clock and cycle conversion
  localparam int CLK_PERIOD_NS = 4;
  function automatic int rcbc_ceil_div(input int num, input int den);
    return (num + den - 1) / den;
  endfunction

  // Register byte addresses
  localparam logic [7:0] RCC_OFFSET  = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;

  // Reset cause/control field positions
  localparam int IRQ_PRIORITY_ENABLE_BIT = 7;
  localparam int SBOR_BIT = 6;
  localparam int RI_BIT   = 4;
  localparam int TO_BIT   = 3;
  localparam int PD_BIT   = 2;
  localparam int POR_BIT  = 1;
  localparam int BOR_BIT  = 0;

  // Reset values of the cause/control bits
  localparam logic IRQ_PRIORITY_ENABLE_RST = 1'b0;
  localparam logic SBOR_RST = 1'b1;
  localparam logic RI_RST   = 1'b1;
  localparam logic TO_RST   = 1'b1;
  localparam logic PD_RST   = 1'b1;
  localparam logic POR_RST  = 1'b0;
  localparam logic BOR_RST  = 1'b0;

  // Brown-out configuration codes
  localparam logic [1:0] BOR_OFF  = 2'h0;
  localparam logic [1:0] BOR_SW   = 2'h1;
  localparam logic [1:0] BOR_NOSL = 2'h2;
  localparam logic [1:0] BOR_ON   = 2'h3;

  // Timing figures
  localparam int BOR_MIN_NS    = 200;
  localparam int BOR_MIN_CYC   = rcbc_ceil_div(BOR_MIN_NS, CLK_PERIOD_NS);
  localparam int PIN_FILT_NS   = 100;
  localparam int PIN_FILT_CYC  = rcbc_ceil_div(PIN_FILT_NS, CLK_PERIOD_NS);
  localparam int POWERUP_DELAY_TIMER_TICKS    = 2048;
  localparam int OST_TICKS     = 1024;
  localparam int PLL_LOCK_NS   = 2000000;
  localparam int PLL_LOCK_CYC  = PLL_LOCK_NS / CLK_PERIOD_NS;

  // Start-up sequencer states
  typedef enum logic [4:0] {
    ST_HOLD = 5'h01,
    ST_POWERUP_DELAY_TIMER = 5'h02,
    ST_OST  = 5'h04,
    ST_PLL  = 5'h08,
    ST_DONE = 5'h10
  } rcbc_state_type;
endpackage

/* verification/rcbc_chk_sva.sv */
`timescale 1ns/1ps
module rcbc_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        ext_reset_pin_in,
  input wire logic        ext_reset_pin_out,
  input wire logic        ext_reset_pin_oe,
  input wire logic        ext_pin_din,
  input wire logic        ext_reset_pin_enable,
  input wire logic        por_pulse,
  input wire logic [1:0]  brownout_cfg,
  input wire logic [1:0]  brownout_level_cfg,
  input wire logic        sleep_mode,
  input wire logic        device_reset_n,
  input wire logic        irq_priority_enable,
  input wire logic        brownout_det_en,
  input wire logic [1:0]  brownout_level
);
  import rcbc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] pin_low_q;
  wire logic  irq_priority_enable_wdata = pwdata[IRQ_PRIORITY_ENABLE_BIT];
  // Length of the current low run on an enabled reset pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_low_q <= 8'h00;
    else if (ext_reset_pin_in || !ext_reset_pin_enable)
      pin_low_q <= 8'h00;
    else if (pin_low_q != 8'hff)
      pin_low_q <= pin_low_q + 8'h01;
  end
  property p_pin_never_driven;
    ext_reset_pin_oe == 1'b0 && ext_reset_pin_out == 1'b0;
  endproperty
  a_pin_never_driven: assert property (p_pin_never_driven) else $error("reset pin driven");
  property p_pin_hold;
    pin_low_q >= 8'h28 |-> !device_reset_n;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("long pin low without reset");
  property p_pin_input;
    ext_reset_pin_enable && $past(ext_reset_pin_enable) |-> ext_pin_din;
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("pin input not idle");
  property p_por_hold;
    por_pulse [*4] |-> !device_reset_n;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("released during power-on");
  property p_sbor_hidden;
    pready && !pwrite && paddr == RCC_OFFSET && brownout_cfg != BOR_SW && $stable(brownout_cfg)
      |-> prdata[SBOR_BIT] == 1'b0;
  endproperty
  a_sbor_hidden: assert property (p_sbor_hidden) else $error("enable bit visible");
  property p_irq_priority_enable;
    pready && pwrite && paddr == RCC_OFFSET |-> ##2 irq_priority_enable == $past(irq_priority_enable_wdata, 2);
  endproperty
  a_irq_priority_enable: assert property (p_irq_priority_enable) else $error("priority enable wrong");
  property p_off;
    (brownout_cfg == BOR_OFF) [*3] |-> !brownout_det_en;
  endproperty
  a_off: assert property (p_off) else $error("detection on while off");
  property p_nosleep;
    (brownout_cfg == BOR_NOSL && sleep_mode) [*3] |-> !brownout_det_en;
  endproperty
  a_nosleep: assert property (p_nosleep) else $error("detection on in sleep");
  property p_level;
    1'b1 |=> brownout_level == $past(brownout_level_cfg);
  endproperty
  a_level: assert property (p_level) else $error("trip level wrong");
endmodule // rcbc_chk

bind rcbc_top rcbc_chk i_rcbc_chk (.pclk, .presetn, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .ext_reset_pin_in, .ext_reset_pin_out, .ext_reset_pin_oe, .ext_pin_din, .ext_reset_pin_enable,
  .por_pulse, .brownout_cfg, .brownout_level_cfg, .sleep_mode, .device_reset_n, .irq_priority_enable,
  .brownout_det_en, .brownout_level);

/* verification/rcbc_supply_model.sv */
`timescale 1ns/1ps
module rcbc_supply_model (
  input  wire logic pclk,
  input  wire logic por_req,
  input  wire logic low_req,
  input  wire logic pin_low_req,
  output logic      por_pulse,
  output logic      supply_low,
  output logic      ext_reset_pin_in,
  output logic      internal_slow_osc,
  output logic      xtal_osc_in
);
  logic [3:0] slow_q = 4'h0;
  logic [2:0] xtal_q = 3'h0;
  // Free-running oscillators, slow one at a sixteenth, crystal at a sixth
  always_ff @(posedge pclk)
  begin
    slow_q <= slow_q + 4'h1;
    xtal_q <= (xtal_q == 3'h5) ? 3'h0 : xtal_q + 3'h1;
  end
  assign internal_slow_osc = slow_q[3];
  assign xtal_osc_in = (xtal_q < 3'h3);
  // Supply monitors and pin with pull-up, released pin reads high
  assign por_pulse = por_req;
  assign supply_low = low_req;
  assign ext_reset_pin_in = !pin_low_req;
endmodule // rcbc_supply_model

/* verification/rcbc_top_tb.sv */
`timescale 1ns/1ps
module rcbc_top_tb;
  import rcbc_pkg::*;
  localparam logic [32:0] ALL = 33'h1ffffffff;
  logic        pclk, pready, pslverr, ext_reset_pin_in, ext_reset_pin_out, ext_reset_pin_oe, ext_pin_din;
  logic        por_pulse, supply_low, internal_slow_osc, xtal_osc_in, device_reset_n;
  logic        irq_priority_enable, brownout_det_en;
  logic        presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        ext_reset_pin_enable = 1'b1, powerup_delay_off = 1'b0, osc_startup_en = 1'b1;
  logic        pll_enable = 1'b1, sleep_mode = 1'b0, por_req = 1'b1, low_req = 1'b0, pin_low_req = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] prdata, pwdata = 32'h0, lfsr = 32'h0001686c;
  logic [1:0]  brownout_level, brownout_cfg = BOR_SW, brownout_level_cfg = 2'h0;
  logic [3:0]  evt = 4'h0;
  logic [32:0] exp_q[$], msk_q[$];
  int          fails = 0, tests_run = 0, cyc = 0, n;

  rcbc_top #(.POWERUP_DELAY_TIMER_CNT(4), .OST_CNT(4), .PLL_CNT(10)) i_rcbc_top (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_reset_pin_in, .ext_reset_pin_out,
    .ext_reset_pin_oe, .ext_pin_din, .por_pulse, .supply_low, .internal_slow_osc, .xtal_osc_in,
    .ext_reset_pin_enable, .powerup_delay_off, .osc_startup_en, .pll_enable, .brownout_cfg,
    .brownout_level_cfg, .sleep_mode, .reset_instr_evt(evt[0]), .watchdog_timeout_evt(evt[1]),
    .watchdog_clear_evt(evt[2]), .sleep_evt(evt[3]), .device_reset_n, .irq_priority_enable,
    .brownout_det_en, .brownout_level);
  rcbc_supply_model i_rcbc_supply_model (.pclk, .por_req, .low_req, .pin_low_req, .por_pulse,
    .supply_low, .ext_reset_pin_in, .internal_slow_osc, .xtal_osc_in);

  // Bus clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic report_and_stop;
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] e, input logic [32:0] m);
    tests_run++;
    if ((seen & m) !== e)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, e, seen & m);
    end
  endtask

  task automatic hold(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // One bus transfer; reads leave their expectation for the monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                     input logic [32:0] m);
    if (!wr)
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    lfsr = lfsr_next(lfsr);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {lfsr[31:8], d[7:0]};
    brownout_level_cfg <= lfsr[1:0];
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    @(posedge pclk);
    evt <= 4'h0;
    @(posedge pclk);
  endtask

  task automatic wait_rel;
    n = 0;
    while (device_reset_n !== 1'b1)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Pin or supply held low for k cycles, status and pin input checked meanwhile
  task automatic drop(input logic pin, input int k, input logic [32:0] e);
    if (pin)
      pin_low_req <= 1'b1;
    else
      low_req <= 1'b1;
    hold(k);
    apb(1'b0, STAT_OFFSET, 0, e, 33'h380);
    chk("pin input", ext_pin_din, ext_reset_pin_enable | !pin, 1);
    pin_low_req <= 1'b0;
    low_req <= 1'b0;
    hold(5);
  endtask

  // Read results compared in order of issue
  always @(posedge pclk)
  begin
    if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
      chk("read data", {pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
  end

  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  initial
  begin
    hold(20);
    presetn <= 1'b1;
    hold(5);
    por_req <= 1'b0;
    wait_rel();
    chk("release delay", n > 64, 1, 1);
    apb(1'b0, RCC_OFFSET, 0, 33'h5c, ALL);
    apb(1'b1, RCC_OFFSET, 32'hff, 0, 0);
    apb(1'b0, RCC_OFFSET, 0, 33'hdf, ALL);
    apb(1'b1, STAT_OFFSET, 32'hff, 0, 0);
    apb(1'b0, STAT_OFFSET, 0, 0, 33'h80);
    apb(1'b0, 8'h08, 0, 33'h100000000, ALL);
    apb(1'b1, RCC_OFFSET, 0, 0, 0);
    apb(1'b0, RCC_OFFSET, 0, 33'h0c, ALL);
    apb(1'b1, RCC_OFFSET, 32'hff, 0, 0);
    sleep_mode <= 1'b1;
    pulse(3);
    apb(1'b0, RCC_OFFSET, 0, 33'hdb, ALL);
    pulse(1);
    apb(1'b0, RCC_OFFSET, 0, 33'hd3, ALL);
    pulse(2);
    apb(1'b0, RCC_OFFSET, 0, 33'hdf, ALL);
    sleep_mode <= 1'b0;
    pulse(0);
    hold(5);
    wait_rel();
    apb(1'b0, RCC_OFFSET, 0, 33'hcf, ALL);
    brownout_cfg <= BOR_OFF;
    hold(4);
    brownout_cfg <= BOR_ON;
    hold(4);
    apb(1'b0, RCC_OFFSET, 0, 33'h8f, ALL);
    brownout_cfg <= BOR_NOSL;
    sleep_mode <= 1'b1;
    drop(1'b0, 80, 0);
    sleep_mode <= 1'b0;
    brownout_cfg <= BOR_SW;
    drop(1'b0, 10, 0);
    drop(1'b0, 80, 33'h280);
    hold(20);
    drop(1'b0, 80, 33'h280);
    wait_rel();
    chk("release delay", n > 50, 1, 1);
    apb(1'b0, RCC_OFFSET, 0, 33'hde, ALL);
    drop(1'b1, 8, 0);
    drop(1'b1, 60, 33'h180);
    wait_rel();
    ext_reset_pin_enable <= 1'b0;
    drop(1'b1, 60, 0);
    ext_reset_pin_enable <= 1'b1;
    apb(1'b1, RCC_OFFSET, 32'hff, 0, 0);
    powerup_delay_off <= 1'b1;
    por_req <= 1'b1;
    hold(10);
    por_req <= 1'b0;
    wait_rel();
    chk("release delay", n < 64, 1, 1);
    apb(1'b0, RCC_OFFSET, 0, 33'h5c, 33'h1ffffff7f);
    hold(5);
    report_and_stop();
  end
endmodule // rcbc_top_tb
